// ==== hw/fir_irq_map.svh ====
// Register map and field constants of the load status and interrupt block
// Notes on behaviour
// - Load status bit 1 reads complete
// - Load status bit 0 reads in progress
// - Enabled source interrupts on live rising edge
// - Saturation enable bit 0, read/write, resets 0
// - Live saturation bit 0 follows condition, resets 0
// - Live bit rising also sets latched flag
// - Live bit clears when condition goes away
// - Flag holds until software clears it
// - Saturation counts only while filter engaged
// - Writes to live status register ignored
// - Write one clears flag; zero keeps it
// - Interrupt pulse is one clock wide
// - Enabled sources ORed onto one output
// - Flags latch regardless of enable
`ifndef FIR_IRQ_MAP_SVH
`define FIR_IRQ_MAP_SVH
`define OFS_COEFF_LOAD_STATUS 8'h10
`define OFS_IRQ_ENABLE        8'h14
`define OFS_IRQ_LIVE_STATUS   8'h18
`define OFS_IRQ_FLAG          8'h1c
`define BIT_LOAD_IN_PROGRESS  0
`define BIT_LOAD_COMPLETE     1
`define BIT_SAT               0
`endif

// ==== hw/fir_irq_pkg.sv ====
// Types shared by the load status and interrupt block
package fir_irq_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  addr_t;
  typedef enum logic [2:0] {
    LD_IDLE   = 3'b001,
    LD_BUSY   = 3'b010,
    COEFF_LOAD_COMPLETE   = 3'b100
  } load_state_e;
endpackage

// ==== hw/fir_load_status_and_irq.sv ====
// Coefficient load status and saturation interrupt registers
`timescale 1ns/1ps
`default_nettype none
`include "fir_irq_map.svh"
module fir_load_status_and_irq #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Register port
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire fir_irq_pkg::addr_t   reg_addr,
  input  wire fir_irq_pkg::word_t   reg_wdata,
  output var  fir_irq_pkg::word_t   reg_rdata,
  // Stream-domain status
  input  wire logic                 sat_raw,
  input  wire logic                 filter_engaged,
  input  wire logic                 coeff_transfer_trigger,
  input  wire logic                 coeff_transfer_finished,
  // Status outputs
  output logic                      coeff_load_complete,
  output logic                      coeff_load_in_progress,
  output logic                      irq
);
  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : g_bad
    $error("SYNC_STAGES must be at least 2");
  end

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  // Only the last stage is read; earlier stages may be metastable
  logic [SYNC_STAGES-1:0] sy_r [3];
  logic [2:0]             sy_in;
  logic [2:0]             sy_out;
  logic                   sat_gated;
  // Bypassed saturation is dropped before it can reach any flop
  assign sat_gated = sat_raw & filter_engaged;
  // Loader levels must stay up two clocks or they may be missed
  assign sy_in     = {coeff_transfer_finished, coeff_transfer_trigger,
                      sat_gated};
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sy_r[gi] <= '0;
      end else begin
        sy_r[gi] <= {sy_r[gi][SYNC_STAGES-2:0], sy_in[gi]};
      end
    end
    assign sy_out[gi] = sy_r[gi][SYNC_STAGES-1];
  end

  // ------------------------------------------------------------
  // Load progress
  // ------------------------------------------------------------
  fir_irq_pkg::load_state_e ld_r;
  fir_irq_pkg::load_state_e ld_nxt;
  logic                     trig_prev_r;
  logic                     trig_rise;

  // A trigger level held past the end of a load must not restart it
  assign trig_rise = sy_out[1] & ~trig_prev_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= sy_out[1];
    end
  end

  always_comb begin
    ld_nxt = ld_r;
    case (ld_r)
      fir_irq_pkg::LD_IDLE,
      fir_irq_pkg::COEFF_LOAD_COMPLETE: begin
        if (trig_rise) begin
          ld_nxt = fir_irq_pkg::LD_BUSY;
        end
      end
      fir_irq_pkg::LD_BUSY: begin
        if (sy_out[2]) begin
          ld_nxt = fir_irq_pkg::COEFF_LOAD_COMPLETE;
        end
      end
      default: ld_nxt = fir_irq_pkg::LD_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_r <= fir_irq_pkg::LD_IDLE;
    end else begin
      ld_r <= ld_nxt;
    end
  end
  // Complete stays high until the next load begins

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  localparam int W = $bits(fir_irq_pkg::word_t);
  // Shared by the write side and the read mux
  function automatic logic addr_hit(input fir_irq_pkg::addr_t a,
                                    input fir_irq_pkg::addr_t ofs);
    addr_hit = (a == ofs);
  endfunction
  function automatic fir_irq_pkg::word_t place_bit(input logic v,
                                                   input int   pos);
    place_bit      = '0;
    place_bit[pos] = v;
  endfunction
  logic hit_status;
  logic hit_en;
  logic hit_live;
  logic hit_flag;

  // Writes to the read-only offsets have no register to land in
  assign hit_status = addr_hit(reg_addr, `OFS_COEFF_LOAD_STATUS);
  assign hit_en     = addr_hit(reg_addr, `OFS_IRQ_ENABLE);
  assign hit_live   = addr_hit(reg_addr, `OFS_IRQ_LIVE_STATUS);
  assign hit_flag   = addr_hit(reg_addr, `OFS_IRQ_FLAG);

  // ------------------------------------------------------------
  // Interrupt registers
  // ------------------------------------------------------------
  logic sat_en_r;
  logic sat_en_nxt;
  logic sat_live_r;
  logic sat_flag_r;
  logic sat_flag_nxt;
  logic irq_r;
  logic irq_nxt;
  logic sat_rise;
  logic flag_clr;

  // A held condition stays quiet after service; only edges count
  assign sat_rise     = sy_out[0] & ~sat_live_r;
  assign flag_clr     = reg_wr & hit_flag & reg_wdata[`BIT_SAT];
  assign sat_en_nxt   = (reg_wr & hit_en) ? reg_wdata[`BIT_SAT]
                                          : sat_en_r;
  // Set wins over a clear in the same cycle, so no event is lost
  assign sat_flag_nxt = sat_rise | (sat_flag_r & ~flag_clr);
  // Enable is used as it stands; setting it later fires nothing
  assign irq_nxt      = sat_rise & sat_en_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sat_en_r <= 1'b0;
    end else begin
      sat_en_r <= sat_en_nxt;
    end
  end

  // Live bit ignores writes and tracks the condition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sat_live_r <= 1'b0;
    end else begin
      sat_live_r <= sy_out[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sat_flag_r <= 1'b0;
    end else begin
      sat_flag_r <= sat_flag_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Registered read data holds until the next read strobe
  fir_irq_pkg::word_t rdata_r;
  fir_irq_pkg::word_t rdata_nxt;
  fir_irq_pkg::word_t status_word;
  fir_irq_pkg::word_t enable_word;
  fir_irq_pkg::word_t live_word;
  fir_irq_pkg::word_t flag_word;
  fir_irq_pkg::word_t rd_mux;

  assign status_word = place_bit(coeff_load_complete, `BIT_LOAD_COMPLETE)
                     | place_bit(coeff_load_in_progress,
                                 `BIT_LOAD_IN_PROGRESS);
  assign enable_word = place_bit(sat_en_r, `BIT_SAT);
  assign live_word   = place_bit(sat_live_r, `BIT_SAT);
  assign flag_word   = place_bit(sat_flag_r, `BIT_SAT);
  // Unmapped offsets select nothing and read as zero
  assign rd_mux      = ({W{hit_status}} & status_word)
                     | ({W{hit_en}}     & enable_word)
                     | ({W{hit_live}}   & live_word)
                     | ({W{hit_flag}}   & flag_word);
  assign rdata_nxt   = reg_rd ? rd_mux : rdata_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // One-hot state makes the two bits mutually exclusive
  assign coeff_load_in_progress = (ld_r == fir_irq_pkg::LD_BUSY);
  assign coeff_load_complete    = (ld_r == fir_irq_pkg::COEFF_LOAD_COMPLETE);
  // Registered pulse keeps the interrupt line free of glitches
  assign irq       = irq_r;
  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// ==== tb/fir_irq_props.sv ====
// Port assertions for the load status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module fir_irq_props (
  input wire logic               clk, rst_n, reg_rd, sat_raw, irq,
  input wire logic               filter_engaged, coeff_load_complete,
  input wire logic               coeff_load_in_progress,
  input wire fir_irq_pkg::addr_t reg_addr,
  input wire fir_irq_pkg::word_t reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Five cycles clear the two sync stages and the live register
  sequence byp_s; !filter_engaged [*5]; endsequence
  sequence calm_s; !sat_raw [*5]; endsequence
  AST_BOTH: assert property (!(coeff_load_complete &&
    coeff_load_in_progress)) else $error("both load bits");
  AST_RISE: assert property ($rose(coeff_load_complete) |->
    $fell(coeff_load_in_progress)) else $error("complete rose alone");
  AST_PULSE: assert property (irq |=> !irq)
    else $error("irq wider than one cycle");
  AST_BYP: assert property (byp_s |-> !irq)
    else $error("irq while bypassed");
  AST_CALM: assert property (calm_s |-> !irq)
    else $error("irq without edge");
  AST_LIVE: assert property (calm_s ##1 reg_rd && reg_addr == 8'h18
    |=> reg_rdata == 32'h0) else $error("live bit stuck");
  AST_STAT: assert property (reg_rd && reg_addr == 8'h10 |=>
    reg_rdata == {30'h0, $past(coeff_load_complete),
    $past(coeff_load_in_progress)}) else $error("status read");
endmodule
bind fir_load_status_and_irq fir_irq_props i_fir_irq_props (
  .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .sat_raw(sat_raw), .irq(irq),
  .filter_engaged(filter_engaged),
  .coeff_load_complete(coeff_load_complete),
  .coeff_load_in_progress(coeff_load_in_progress),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata));
`default_nettype wire

// ==== tb/tb_fir_load_status_and_irq.sv ====
// Self-checking bench for the load status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_fir_load_status_and_irq;
  typedef struct {logic [7:0] a; logic [31:0] d, e;} row_s;
  row_s rows[4] = '{'{8'h14, 32'hffffffff, 32'h1}, '{8'h14, 32'h0, 32'h0},
    '{8'h18, 32'h1, 32'h0}, '{8'h10, 32'h3, 32'h0}};
  logic clk, rst_n, reg_wr, reg_rd, sat_raw, filter_engaged, irq;
  logic coeff_transfer_trigger, coeff_transfer_finished;
  logic coeff_load_complete, coeff_load_in_progress;
  fir_irq_pkg::addr_t reg_addr;
  fir_irq_pkg::word_t reg_wdata, reg_rdata;
  int bad_count, check_count, irqs;
  fir_irq_pkg::word_t pins;
  assign pins = {30'h0, coeff_load_complete, coeff_load_in_progress};
  fir_load_status_and_irq i_fir_load_status_and_irq (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sat_raw(sat_raw), .filter_engaged(filter_engaged),
    .coeff_transfer_trigger(coeff_transfer_trigger),
    .coeff_transfer_finished(coeff_transfer_finished),
    .coeff_load_complete(coeff_load_complete),
    .coeff_load_in_progress(coeff_load_in_progress), .irq(irq));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'h1) irqs++;
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(string n, fir_irq_pkg::word_t e, fir_irq_pkg::word_t g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, fir_irq_pkg::word_t d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, ~w, a, d};
    cyc(1);
    {reg_wr, reg_rd} = 2'h0;
    cyc(1);
  endtask
  task automatic rdc(string n, logic [7:0] a, fir_irq_pkg::word_t e);
    acc(1'h0, a, 32'h0);
    chk(n, e, reg_rdata);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, sat_raw} = '0;
    {filter_engaged, coeff_transfer_trigger, coeff_transfer_finished} = '0;
    cyc(16);
    rst_n = 1'h1;
    cyc(2);
    foreach (rows[i]) begin
      acc(1'h1, rows[i].a, rows[i].d);
      rdc("row", rows[i].a, rows[i].e);
    end
    $display("register rows done");
    {filter_engaged, sat_raw} = 2'h3;
    cyc(6);
    rdc("live on", 8'h18, 32'h1);
    sat_raw = 1'h0;
    cyc(6);
    rdc("live off", 8'h18, 32'h0);
    acc(1'h1, 8'h1c, 32'h0);
    rdc("flag", 8'h1c, 32'h1);
    chk("irq masked", 32'h0, irqs);
    acc(1'h1, 8'h1c, 32'h1);
    rdc("flag clr", 8'h1c, 32'h0);
    acc(1'h1, 8'h14, 32'h1);
    sat_raw = 1'h1;
    cyc(12);
    chk("irq one", 32'h1, irqs);
    {filter_engaged, sat_raw} = 2'h0;
    cyc(6);
    sat_raw = 1'h1;
    cyc(8);
    rdc("bypass", 8'h18, 32'h0);
    chk("irq bypass", 32'h1, irqs);
    sat_raw = 1'h0;
    $display("interrupt tests done");
    coeff_transfer_trigger = 1'h1;
    cyc(2);
    coeff_transfer_trigger = 1'h0;
    cyc(5);
    rdc("busy", 8'h10, 32'h1);
    chk("busy pins", 32'h1, pins);
    coeff_transfer_finished = 1'h1;
    cyc(2);
    coeff_transfer_finished = 1'h0;
    cyc(5);
    rdc("done", 8'h10, 32'h2);
    chk("done pins", 32'h2, pins);
    rst_n = 1'h0;
    cyc(2);
    rst_n = 1'h1;
    cyc(2);
    rdc("rst en", 8'h14, 32'h0);
    rdc("rst flag", 8'h1c, 32'h0);
    chk("rst pins", 32'h0, pins);
    $display("load and reset tests done");
    results;
  end
  // Tests need about 115 cycles; the limit leaves wide margin
  initial begin
    #100000;
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
